// ==== rtl/ohp_top.sv ====
// host command port: pin decode, byte fifo, command engine and frame memory
`timescale 1ns/1ps
// Notes on behaviour
// - a byte with the select line low is a command, high is a data or parameter byte.
// - every configuration value returns to its default while the reset input is low.
// - drivers come on 200 milliseconds after the display-on command is taken.
// - frame memory holds 128 by 128 pixels of three six-bit sub-pixels.
// - with remap set, output n shows memory column or row 127 minus n.
// - configuration commands are ignored until the lock command gets the unlock byte.
// - the read/write pin is the write strobe for 8080 and direction for 6800.
// - the enable/read pin is the read strobe for 8080 and the enable for 6800.

// ------------------------------------------------------------
// byte fifo
// ------------------------------------------------------------
module ohp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [PW:0] cnt;
  logic push;
  logic pop;
  assign o_ready = cnt != (PW+1)'(DEPTH);
  assign o_valid = cnt != '0;
  assign o_data = mem[rp];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp] <= i_data;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= push ? PW'(wp + 1'b1) : wp;
      rp <= pop ? PW'(rp + 1'b1) : rp;
      cnt <= (PW+1)'(cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
    end
  end
endmodule

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module ohp_top import ohp_pkg::*; #(
  parameter int unsigned P_DISP_ON_CYCLES = DISP_ON_CYC
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  // host bus pins
  input wire logic I_RESET_N_INPUT,
  input wire logic I_BUS_SELECT_HI,
  input wire logic I_BUS_SELECT_LO,
  input wire logic I_CS_N,
  input wire logic I_DC,
  input wire logic I_RW,
  input wire logic I_E_RD,
  input wire logic [7:0] I_DATA,
  output logic [7:0] O_DATA,
  output logic O_DATA_OE,
  output logic O_BUSY,
  // panel side
  input wire logic [6:0] I_SCAN_COL,
  input wire logic [6:0] I_SCAN_ROW,
  output logic [17:0] O_SCAN_PIXEL,
  output logic O_DRIVERS_ON,
  output logic O_COL_REMAP,
  output logic O_ROW_REMAP
);
  localparam logic [23:0] ON_LAST = 24'(P_DISP_ON_CYCLES - 1);
  logic rst_meta;
  logic rst_n;
  ohp_state_t st;
  ohp_state_t nx;
  ohp_xfer_t fifo_out;
  logic fifo_valid;
  logic fifo_in_ready;
  logic pop;
  logic wr_evt;
  logic rd_act;
  logic last_byte;
  logic [1:0] bus_mode;
  logic [15:0] pix16;
  logic [PIX_W-1:0] frame_memory [MEM_WORDS];
  logic [PIX_W-1:0] scan_pix;

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ohp_fifo #(.WIDTH(BYTE_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLK_SYS),
    .i_rst_n(rst_n),
    .i_valid(st.cap_valid),
    .i_data(st.cap),
    .o_ready(fifo_in_ready),
    .o_valid(fifo_valid),
    .o_data(fifo_out),
    .i_ready(!st.wr_pend)
  );

  // the one-cycle memory write stalls the drain, so bursts back up into the fifo
  assign pop = fifo_valid && !st.wr_pend;
  assign bus_mode = {I_BUS_SELECT_HI, I_BUS_SELECT_LO};
  assign last_byte = st.depth262 ? (st.pidx == 2'h2) : (st.pidx == 2'h1);
  assign pix16 = {st.pix_buf[7:0], fifo_out.byte_val};

  always_comb begin
    nx = st;
    wr_evt = 1'b0;
    rd_act = 1'b0;
    if (!I_CS_N && bus_mode == BUS_8080) begin
      wr_evt = I_RW && !st.prev_wr;
      rd_act = !I_E_RD;
    end else if (!I_CS_N && bus_mode == BUS_6800) begin
      wr_evt = !I_RW && st.prev_e && !I_E_RD;
      rd_act = I_RW && I_E_RD;
    end
    nx.prev_wr = I_RW;
    nx.prev_e = I_E_RD;
    nx.cap_valid = st.cap_valid && !fifo_in_ready;
    // a byte that arrives while the fifo is full overwrites the held one
    if (wr_evt) begin
      nx.cap_valid = 1'b1;
      nx.cap = '{dc: I_DC, byte_val: I_DATA};
    end
    nx.busy = !fifo_in_ready;
    nx.rd_oe = rd_act;
    nx.rd_data = {5'h00, st.depth262, st.locked, st.disp_on};
    nx.wr_pend = 1'b0;
    if (st.on_pend) begin
      if (st.on_cnt == ON_LAST) begin
        nx.disp_on = 1'b1;
        nx.on_pend = 1'b0;
      end else begin
        nx.on_cnt = st.on_cnt + 24'h000001;
      end
    end
    nx.scan_addr = {st.row_remap ? 7'(ADDR_LAST - I_SCAN_ROW) : I_SCAN_ROW,
                    st.col_remap ? 7'(ADDR_LAST - I_SCAN_COL) : I_SCAN_COL};
    if (pop) begin
      if (!fifo_out.dc) begin
        nx.pidx = 2'h0;
        nx.phase = ST_CMD;
        if (fifo_out.byte_val == CMD_LOCK) begin
          nx.phase = ST_PARAM;
          nx.cmd = CMD_LOCK;
        end else if (!st.locked) begin
          case (fifo_out.byte_val)
            CMD_DISP_ON: begin
              if (!st.disp_on && !st.on_pend) begin
                nx.on_pend = 1'b1;
                nx.on_cnt = 24'h000000;
              end
            end
            CMD_DISP_OFF: begin
              nx.disp_on = 1'b0;
              nx.on_pend = 1'b0;
            end
            CMD_WR_MEM: begin
              nx.phase = ST_PIXEL;
              nx.col = st.col_s;
              nx.row = st.row_s;
            end
            default: begin
              nx.phase = ST_PARAM;
              nx.cmd = fifo_out.byte_val;
            end
          endcase
        end
      end else if (st.phase == ST_PARAM) begin
        nx.pidx = 2'(st.pidx + 1'b1);
        case (st.cmd)
          CMD_LOCK: nx.locked = fifo_out.byte_val != UNLOCK_KEY;
          CMD_REMAP: begin
            nx.col_remap = fifo_out.byte_val[REMAP_COL_BIT];
            nx.row_remap = fifo_out.byte_val[REMAP_ROW_BIT];
            nx.depth262 = fifo_out.byte_val[7:6] == DEPTH_262K;
          end
          CMD_COL_WIN: begin
            if (st.pidx == 2'h0) begin
              nx.col_s = fifo_out.byte_val[6:0];
            end else begin
              nx.col_e = fifo_out.byte_val[6:0];
            end
          end
          CMD_ROW_WIN: begin
            if (st.pidx == 2'h0) begin
              nx.row_s = fifo_out.byte_val[6:0];
            end else begin
              nx.row_e = fifo_out.byte_val[6:0];
            end
          end
          default: nx.pidx = st.pidx;
        endcase
      end else if (st.phase == ST_PIXEL) begin
        nx.pix_buf = {st.pix_buf[9:0], fifo_out.byte_val};
        nx.pidx = 2'(st.pidx + 1'b1);
        if (last_byte) begin
          nx.pidx = 2'h0;
          nx.wr_pend = 1'b1;
          nx.wr_addr = {st.row, st.col};
          // 262k keeps the low six bits of three bytes; 65k widens a 565 pixel to three six-bit sub-pixels
          nx.wr_data = st.depth262 ?
            {st.pix_buf[13:8], st.pix_buf[5:0], fifo_out.byte_val[5:0]} :
            {pix16[15:11], pix16[15], pix16[10:5], pix16[4:0], pix16[4]};
          // advance column, then row, wrapping in the window
          if (st.col == st.col_e) begin
            nx.col = st.col_s;
            nx.row = (st.row == st.row_e) ? st.row_s : 7'(st.row + 1'b1);
          end else begin
            nx.col = 7'(st.col + 1'b1);
          end
        end
      end
    end
    // pin reset returns every setting to default
    if (!I_RESET_N_INPUT) begin
      nx = ST_RESET;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= nx;
    end
  end

  // frame memory, no reset on the array itself
  always_ff @(posedge I_CLK_SYS) begin
    if (st.wr_pend) begin
      frame_memory[st.wr_addr] <= st.wr_data;
    end
    scan_pix <= frame_memory[st.scan_addr];
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      O_SCAN_PIXEL <= '0;
    end else begin
      O_SCAN_PIXEL <= scan_pix;
    end
  end

  assign O_DATA = st.rd_data;
  assign O_DATA_OE = st.rd_oe;
  assign O_BUSY = st.busy;
  assign O_DRIVERS_ON = st.disp_on;
  assign O_COL_REMAP = st.col_remap;
  assign O_ROW_REMAP = st.row_remap;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!rst_n);
  sequence s_pop_cmd(logic [7:0] c);
    pop && !fifo_out.dc && fifo_out.byte_val == c && I_RESET_N_INPUT;
  endsequence
  sequence s_strobe_8080;
    !I_CS_N && bus_mode == BUS_8080 && I_RW && !st.prev_wr;
  endsequence
  sequence s_strobe_6800;
    !I_CS_N && bus_mode == BUS_6800 && !I_RW && st.prev_e && !I_E_RD;
  endsequence
  a_cmd_off_now: assert property (s_pop_cmd(CMD_DISP_OFF) ##0 !st.locked |=> !O_DRIVERS_ON)
    else $error("display off command did not drop drivers");
  a_on_delay: assert property ($rose(O_DRIVERS_ON) |-> $past(st.on_cnt) == ON_LAST)
    else $error("drivers enabled before the full delay");
  a_pin_reset: assert property (!I_RESET_N_INPUT |=> st.locked && !O_DRIVERS_ON
      && !O_COL_REMAP && st.col_e == ADDR_LAST && st.phase == ST_CMD)
    else $error("pin reset left a setting");
  a_scan_remap: assert property (st.col_remap && $stable(st.col_remap) |->
      st.scan_addr[6:0] == 7'(ADDR_LAST - $past(I_SCAN_COL)))
    else $error("remapped column address wrong");
  a_lock_hold: assert property (st.locked && pop && !fifo_out.dc
      && fifo_out.byte_val != CMD_LOCK && I_RESET_N_INPUT |=> st.phase == ST_CMD && st.locked)
    else $error("locked engine took a command");
  a_wr_8080: assert property (s_strobe_8080 ##0 I_RESET_N_INPUT |=> st.cap_valid
      && st.cap.byte_val == $past(I_DATA))
    else $error("8080 write edge missed");
  a_en_6800: assert property (s_strobe_6800 ##0 I_RESET_N_INPUT |=> st.cap_valid
      && st.cap.dc == $past(I_DC))
    else $error("6800 enable edge missed");
  a_win_wrap: assert property (st.wr_pend |-> $past(st.col) == $past(st.col_e) ?
      st.col == $past(st.col_s) : st.col == 7'($past(st.col) + 1'b1))
    else $error("window column did not advance");
  a_pix_pack: assert property (st.wr_pend && !st.depth262 |->
      st.wr_data[17:13] == $past(st.pix_buf[7:3]))
    else $error("red field misplaced");
endmodule

// ==== include/ohp_pkg.sv ====
// constants and types of the host command port
package ohp_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int DISP_ON_DELAY_MS = 200;
  localparam int DISP_ON_CYC = DISP_ON_DELAY_MS * (CLK_FREQ_HZ / 1000);
  // ------------------------------------------------------------
  // command bytes and parameter fields
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_LOCK = 8'hFD;
  localparam logic [7:0] UNLOCK_KEY = 8'hB1;
  localparam logic [7:0] CMD_DISP_ON = 8'hAF;
  localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0] CMD_REMAP = 8'hA0;
  localparam logic [7:0] CMD_COL_WIN = 8'h15;
  localparam logic [7:0] CMD_ROW_WIN = 8'h75;
  localparam logic [7:0] CMD_WR_MEM = 8'h5C;
  localparam int REMAP_COL_BIT = 1;
  localparam int REMAP_ROW_BIT = 4;
  localparam logic [1:0] DEPTH_262K = 2'h2;
  localparam logic [1:0] BUS_8080 = 2'h3;
  localparam logic [1:0] BUS_6800 = 2'h2;
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int PIX_W = 18;
  localparam int ADDR_W = 7;
  localparam int MEM_WORDS = 16384;
  localparam logic [6:0] ADDR_LAST = 7'h7F;
  localparam int FIFO_DEPTH = 8;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic dc;
    logic [7:0] byte_val;
  } ohp_xfer_t;
  typedef enum logic [1:0] {ST_CMD, ST_PARAM, ST_PIXEL} ohp_phase_t;
  typedef struct packed {
    ohp_phase_t phase;
    logic locked;
    logic disp_on;
    logic on_pend;
    logic [23:0] on_cnt;
    logic col_remap;
    logic row_remap;
    logic depth262;
    logic [7:0] cmd;
    logic [1:0] pidx;
    logic [6:0] col_s;
    logic [6:0] col_e;
    logic [6:0] row_s;
    logic [6:0] row_e;
    logic [6:0] col;
    logic [6:0] row;
    logic [17:0] pix_buf;
    logic wr_pend;
    logic [13:0] wr_addr;
    logic [17:0] wr_data;
    logic prev_wr;
    logic prev_e;
    logic cap_valid;
    ohp_xfer_t cap;
    logic busy;
    logic rd_oe;
    logic [7:0] rd_data;
    logic [13:0] scan_addr;
  } ohp_state_t;
  localparam ohp_state_t ST_RESET = '{
    phase: ST_CMD, locked: 1'b1, disp_on: 1'b0, on_pend: 1'b0, on_cnt: 24'h000000,
    col_remap: 1'b0, row_remap: 1'b0, depth262: 1'b0, cmd: 8'h00, pidx: 2'h0,
    col_s: 7'h00, col_e: 7'h7F, row_s: 7'h00, row_e: 7'h7F, col: 7'h00, row: 7'h00,
    pix_buf: 18'h00000, wr_pend: 1'b0, wr_addr: 14'h0000, wr_data: 18'h00000,
    prev_wr: 1'b1, prev_e: 1'b0, cap_valid: 1'b0, cap: '{dc: 1'b0, byte_val: 8'h00},
    busy: 1'b0, rd_oe: 1'b0, rd_data: 8'h00, scan_addr: 14'h0000};
endpackage

// ==== verif/ohp_host_model.sv ====
// host microcontroller model driving the parallel command port
`timescale 1ns/1ps
module ohp_host_model (
  // clock
  input wire logic i_clk,
  // answers from the port
  input wire logic i_oe,
  input wire logic [7:0] i_rd,
  // bus pins
  output logic o_rst_n,
  output logic o_cs_n,
  output logic o_dc,
  output logic o_rw,
  output logic o_e_rd,
  output logic [7:0] o_data
);
  initial begin
    o_rst_n = 1'b1;
    o_cs_n = 1'b1;
    o_dc = 1'b0;
    o_rw = 1'b1;
    o_e_rd = 1'b1;
    o_data = 8'h5A;
  end
  // core supply settles for 1 ms before the reset pulse
  task automatic power_up();
    repeat (50000) @(posedge i_clk);
    pulse();
  endtask
  // reset pin low for 2 us
  task automatic pulse();
    @(posedge i_clk);
    o_rst_n <= 1'b0;
    repeat (100) @(posedge i_clk);
    o_rst_n <= 1'b1;
  endtask
  // idle strobe: read strobe high for 8080, enable low for 6800
  task automatic idle(input logic md);
    @(posedge i_clk);
    o_e_rd <= !md;
  endtask
  // one byte, select low for commands; bus released to inverse values
  task automatic wr(input logic md, input logic dc, input logic [7:0] b);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_dc <= dc;
    o_data <= b;
    o_rw <= 1'b0;
    o_e_rd <= 1'b1;
    @(posedge i_clk);
    if (md) o_e_rd <= 1'b0;
    else o_rw <= 1'b1;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_rw <= 1'b1;
    o_e_rd <= !md;
    o_dc <= !dc;
    o_data <= ~b;
  endtask
  // back-to-back byte at the fastest strobe spacing; chip select stays low
  task automatic wr_fast(input logic md, input logic dc, input logic [7:0] b);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_dc <= dc;
    o_data <= b;
    o_rw <= 1'b0;
    o_e_rd <= 1'b1;
    @(posedge i_clk);
    if (md) o_e_rd <= 1'b0;
    else o_rw <= 1'b1;
  endtask
  // read held until the answer is sampled
  task automatic rd(input logic md, output logic oe, output logic [7:0] d);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_e_rd <= md;
    repeat (3) @(posedge i_clk);
    #1;
    oe = i_oe;
    d = i_rd;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_e_rd <= !md;
  endtask
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the host command port
`timescale 1ns/1ps
module tb;
  import ohp_pkg::*;
  localparam int unsigned ON_CYC = 20;
  logic clk;
  logic arst_n = 1'b0;
  logic bs_lo = 1'b1;
  logic md = 1'b0;
  logic [6:0] scol = 7'h00;
  logic [6:0] srow = 7'h00;
  logic rst_n, cs_n, dc, rw, e_rd, oe, busy, drv, crm, rrm;
  logic [7:0] hd, rd;
  logic [17:0] pix;
  int n_fail = 0;
  int samples_checked = 0;
  ohp_top #(.P_DISP_ON_CYCLES(ON_CYC)) ohp_top_inst (
    .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_RESET_N_INPUT(rst_n), .I_BUS_SELECT_HI(1'b1),
    .I_BUS_SELECT_LO(bs_lo), .I_CS_N(cs_n), .I_DC(dc), .I_RW(rw), .I_E_RD(e_rd),
    .I_DATA(hd), .O_DATA(rd), .O_DATA_OE(oe), .O_BUSY(busy), .I_SCAN_COL(scol),
    .I_SCAN_ROW(srow), .O_SCAN_PIXEL(pix), .O_DRIVERS_ON(drv), .O_COL_REMAP(crm),
    .O_ROW_REMAP(rrm));
  ohp_host_model ohp_host_model_inst (.i_clk(clk), .i_oe(oe), .i_rd(rd), .o_rst_n(rst_n),
    .o_cs_n(cs_n), .o_dc(dc), .o_rw(rw), .o_e_rd(e_rd), .o_data(hd));
  // ----
  // helpers
  // ----
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic w(input logic c, input logic [7:0] b);
    ohp_host_model_inst.wr(md, c, b);
  endtask
  task automatic st(input logic [7:0] e);
    logic o;
    logic [7:0] d;
    ohp_host_model_inst.rd(md, o, d);
    chk(o === 1'b1 && d === e, "status read");
  endtask
  // scan result is registered three cycles after the index
  task automatic px(input logic [6:0] c, input logic [6:0] r, input logic [17:0] e);
    @(posedge clk);
    scol <= c;
    srow <= r;
    repeat (5) @(posedge clk);
    chk(pix === e, "scan pixel");
  endtask
  task automatic bus(input logic m);
    md = m;
    bs_lo <= !m;
    ohp_host_model_inst.idle(m);
    @(posedge clk);
  endtask
  function automatic logic [17:0] pv(input int k);
    return {6'(k + 1), 6'(k + 16), 6'(63 - k)};
  endfunction
  // ----
  // scenarios
  // ----
  task automatic s_lock();
    bus(1'b1);
    st(8'h02);
    w(1'b0, CMD_DISP_ON);
    repeat (ON_CYC + 20) @(posedge clk);
    chk(drv === 1'b0, "display on while locked");
    w(1'b0, CMD_LOCK);
    w(1'b1, UNLOCK_KEY);
    st(8'h00);
    bus(1'b0);
    st(8'h00);
  endtask
  task automatic s_on();
    int n;
    n = 0;
    w(1'b0, CMD_DISP_ON);
    while (drv !== 1'b1 && n < ON_CYC + 40) begin
      @(posedge clk);
      n++;
    end
    chk(drv === 1'b1 && n >= ON_CYC && n <= ON_CYC + 6, "driver delay");
    if (drv !== 1'b1) tally_and_finish();
    st(8'h01);
    w(1'b0, CMD_DISP_OFF);
    repeat (4) @(posedge clk);
    chk(drv === 1'b0, "display off");
  endtask
  task automatic s_win();
    w(1'b0, CMD_REMAP);
    w(1'b1, 8'h80);
    w(1'b0, CMD_COL_WIN);
    w(1'b1, 8'h02);
    w(1'b1, 8'h03);
    w(1'b0, CMD_ROW_WIN);
    w(1'b1, 8'h05);
    w(1'b1, 8'h06);
    w(1'b0, CMD_WR_MEM);
    for (int k = 0; k < 5; k++) begin
      w(1'b1, {2'b11, 6'(k + 1)});
      w(1'b1, {2'b10, 6'(k + 16)});
      w(1'b1, {2'b01, 6'(63 - k)});
    end
    chk(busy === 1'b0, "port busy");
    px(7'h02, 7'h05, pv(4));
    px(7'h03, 7'h05, pv(1));
    px(7'h02, 7'h06, pv(2));
    px(7'h03, 7'h06, pv(3));
  endtask
  task automatic s_remap();
    w(1'b0, CMD_REMAP);
    w(1'b1, 8'h92);
    repeat (4) @(posedge clk);
    chk(crm === 1'b1 && rrm === 1'b1, "remap flags");
    px(7'h7D, 7'h7A, pv(4));
    st(8'h04);
  endtask
  // a pending display-on must not survive the pin reset
  task automatic s_hwrst();
    w(1'b0, CMD_DISP_ON);
    repeat (3) @(posedge clk);
    ohp_host_model_inst.pulse();
    repeat (ON_CYC + 20) @(posedge clk);
    chk(drv === 1'b0 && crm === 1'b0 && rrm === 1'b0, "pin reset");
    st(8'h02);
    px(7'h02, 7'h05, pv(4));
  endtask
  task automatic s_65k();
    logic [15:0] v [4];
    logic [17:0] e [4];
    v = '{16'hF800, 16'h07E0, 16'h7BEF, 16'h001F};
    // five-bit fields widened by repeating their top bit
    e = '{18'h3F000, 18'h00FC0, 18'h1E7DE, 18'h0003F};
    w(1'b0, CMD_LOCK);
    w(1'b1, UNLOCK_KEY);
    w(1'b0, CMD_REMAP);
    w(1'b1, 8'h00);
    w(1'b0, CMD_WR_MEM);
    for (int k = 0; k < 4; k++) begin
      w(1'b1, v[k][15:8]);
      w(1'b1, v[k][7:0]);
    end
    for (int k = 0; k < 4; k++) begin
      px(7'(k), 7'h00, e[k]);
    end
  endtask
  // bytes at the fastest strobe spacing must cross the byte fifo in order
  task automatic s_fifo();
    w(1'b0, CMD_REMAP);
    w(1'b1, 8'h80);
    w(1'b0, CMD_COL_WIN);
    w(1'b1, 8'h08);
    w(1'b1, 8'h0F);
    w(1'b0, CMD_ROW_WIN);
    w(1'b1, 8'h10);
    w(1'b1, 8'h10);
    w(1'b0, CMD_WR_MEM);
    for (int k = 0; k < 8; k++) begin
      ohp_host_model_inst.wr_fast(md, 1'b1, {2'b11, 6'(k + 1)});
      ohp_host_model_inst.wr_fast(md, 1'b1, {2'b10, 6'(k + 16)});
      if (k < 7) begin
        ohp_host_model_inst.wr_fast(md, 1'b1, {2'b01, 6'(63 - k)});
      end else begin
        w(1'b1, {2'b01, 6'(63 - k)});
      end
    end
    chk(busy === 1'b0, "fifo full during burst");
    px(7'h08, 7'h10, pv(0));
    px(7'h0B, 7'h10, pv(3));
    px(7'h0F, 7'h10, pv(7));
    st(8'h04);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    ohp_host_model_inst.power_up();
    repeat (4) @(posedge clk);
    s_lock();
    s_on();
    s_win();
    s_remap();
    s_hwrst();
    s_65k();
    s_fifo();
    tally_and_finish();
  end
endmodule
